//--- hw/fsp_pkg.sv
// shared constants for the flash command link, both ends
`default_nettype none
package fsp_pkg;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_REWRITE_BUF1 = 8'h58;
  localparam logic [7:0] OP_REWRITE_BUF2 = 8'h59;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  localparam logic [7:0] OP_POWERDOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME = 8'hAB;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] REWRITE_BITS = 6'h20;
  localparam logic [5:0] STATUS_BITS = 6'h10;
  localparam int PAGE_W = 12;
  // page index position inside the 24 address bits
  localparam int PAGE_LSB_528 = 10;
  localparam int PAGE_LSB_512 = 9;
  // ------------------------------------------------------------
  // status byte
  // ------------------------------------------------------------
  localparam int ST_READY_BIT = 7;
  localparam int ST_COMP_BIT = 6;
  localparam int ST_PROT_BIT = 1;
  localparam int ST_SIZE_BIT = 0;
  // density code value is arbitrary
  localparam logic [3:0] DENSITY_CODE = 4'h5;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int COPY_TIME_NS = 10000;
  localparam int REWRITE_TIME_MAX_NS = 40000;
  localparam int POWERDOWN_ENTRY_TIME_NS = 3000;
  localparam int POWERDOWN_EXIT_TIME_NS = 30000;
  localparam int CS_HIGH_MIN_NS = 100;
  localparam logic [15:0] COPY_CYC = 16'((COPY_TIME_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] REWRITE_CYC = 16'((REWRITE_TIME_MAX_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] PROGRAM_CYC = REWRITE_CYC - COPY_CYC;
  localparam logic [15:0] ENTRY_CYC = 16'((POWERDOWN_ENTRY_TIME_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] EXIT_CYC = 16'((POWERDOWN_EXIT_TIME_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] ENTRY_WAIT_CYC =
    16'((POWERDOWN_ENTRY_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] EXIT_WAIT_CYC =
    16'((POWERDOWN_EXIT_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CS_HIGH_CYC = 16'((CS_HIGH_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [4:0] SCK_HALF = 5'h08;
  localparam logic [4:0] SCK_LAST = 5'h0F;
  // ------------------------------------------------------------
  // controller registers
  // ------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_WEAR = 8'h0C;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BUF2_BIT = 2;
  localparam int CMD_PAGE_LSB = 16;
  localparam logic [1:0] HOP_STATUS = 2'h0;
  localparam logic [1:0] HOP_REWRITE = 2'h1;
  localparam logic [1:0] HOP_POWERDOWN = 2'h2;
  localparam logic [1:0] HOP_RESUME = 2'h3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BYTE_LSB = 8;
  localparam int STAT_WEAR_BIT = 16;
  localparam logic [15:0] WEAR_LIMIT = 16'h4E20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- hw/fsp_link_if.sv
// serial link between the controller and the flash device
`default_nettype none
interface fsp_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  logic rdy;
  logic so_line;
  // released line floats high
  assign so_line = so_oe_n ? 1'b1 : so;
  modport device (input cs_n, input sck, input si, output so, output so_oe_n, output rdy);
  modport host (output cs_n, output sck, output si, input so_line, input rdy);
endinterface
`default_nettype wire

//--- hw/fsp_device.sv
// flash device end: page rewrite, status read, deep power-down
`default_nettype none
// Overview of operation
// - opcode 58H/59H starts rewrite, buffer one/two
// - 528 page: 2 skip, 12 page, 10 skip
// - 512 page: 3 skip, BINARY_PAGE_INDEX_BITS page, 9 skip
// - chip select rise: copy, then program back
// - busy during all internal array operations
// - host rewrites each sector page within limit; the host here only counts all rewrites against WEAR_LIMIT
// - status read allowed at any time; refused here from power-down entry until exit ends
// - D7H gives status byte, msb first, eight clocks
// - status byte repeats, freshly sampled each time
// - bit seven high when ready
// - bit six holds last compare mismatch
// - bit one shows protection enabled
// - bit zero high for 512 byte pages
// - bits five to two fixed density code
// - reset lands in standby
// - B9H then chip select rise: power down
// - host raises chip select after last bit
// - powered down: only resume is decoded
// - ABH then chip select rise: back to standby
// - host keeps chip select high during exit
module fsp_device (
  input wire logic SYS_CLK,
  input wire logic RST,
  fsp_link_if.device LINK,
  input wire logic EXT_BUSY,
  input wire logic COMP_MISMATCH,
  input wire logic PROTECT_ON,
  input wire logic PAGE_512,
  output logic REWRITE_START,
  output logic REWRITE_BUF2,
  output logic [fsp_pkg::PAGE_W-1:0] REWRITE_PAGE,
  output logic REWRITE_COPY,
  output logic REWRITE_PROGRAM,
  output logic DEEP_POWER
);

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_COPY,
    ST_PROGRAM,
    ST_ENTER,
    ST_DEEP,
    ST_EXIT
  } fsp_dev_state_type;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] cs_q;
  logic [2:0] sck_q;
  logic [1:0] si_q;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cs_q <= 3'h7;
      sck_q <= 3'h0;
      si_q <= 2'h0;
    end else begin
      cs_q <= {cs_q[1:0], LINK.cs_n};
      sck_q <= {sck_q[1:0], LINK.sck};
      si_q <= {si_q[0], LINK.si};
    end
  end

  wire cs_low = !cs_q[1];
  wire cs_rise = cs_q[1] && !cs_q[2];
  wire sck_rise = sck_q[1] && !sck_q[2];
  wire sck_fall = !sck_q[1] && sck_q[2];

  // ------------------------------------------------------------
  // command shifter
  // ------------------------------------------------------------
  logic [31:0] shift;
  logic [5:0] nbits;

  // frame is cleared while deselected, so a stray clock cannot leak over
  always_ff @(posedge SYS_CLK) begin
    if (RST || !cs_low) begin
      shift <= 32'h0;
      nbits <= 6'h00;
    end else if (sck_rise) begin
      shift <= {shift[30:0], si_q[1]};
      if (nbits != 6'h3F) begin
        nbits <= nbits + 6'h01;
      end
    end
  end

  wire [7:0] rw_opc = shift[31:24];
  wire is_rw_frame = nbits == fsp_pkg::REWRITE_BITS;
  wire go_rw = is_rw_frame &&
    (rw_opc == fsp_pkg::OP_REWRITE_BUF1 || rw_opc == fsp_pkg::OP_REWRITE_BUF2);
  wire go_pd = nbits == fsp_pkg::CMD_BITS && shift[7:0] == fsp_pkg::OP_POWERDOWN;
  wire go_resume = nbits == fsp_pkg::CMD_BITS && shift[7:0] == fsp_pkg::OP_RESUME;
  wire [fsp_pkg::PAGE_W-1:0] page_528 = shift[fsp_pkg::PAGE_LSB_528 +: fsp_pkg::PAGE_W];
  wire [fsp_pkg::PAGE_W-1:0] page_512 = shift[fsp_pkg::PAGE_LSB_512 +: fsp_pkg::PAGE_W];
  wire [fsp_pkg::PAGE_W-1:0] rw_page = PAGE_512 ? page_512 : page_528;

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  fsp_dev_state_type state;
  fsp_dev_state_type next_state;
  logic [15:0] timer;
  logic [15:0] next_timer;

  wire timer_zero = timer == 16'h0000;
  wire busy = state == ST_COPY || state == ST_PROGRAM || EXT_BUSY;
  wire launch_rw = state == ST_STANDBY && cs_rise && go_rw && !EXT_BUSY;

  always_comb begin
    next_state = state;
    next_timer = timer_zero ? timer : timer - 16'h0001;
    case (state)
      ST_STANDBY: begin
        if (launch_rw) begin
          next_state = ST_COPY;
          next_timer = fsp_pkg::COPY_CYC;
        end else if (cs_rise && go_pd && !EXT_BUSY) begin
          next_state = ST_ENTER;
          next_timer = fsp_pkg::ENTRY_CYC;
        end
      end
      ST_COPY: begin
        if (timer_zero) begin
          next_state = ST_PROGRAM;
          next_timer = fsp_pkg::PROGRAM_CYC;
        end
      end
      ST_PROGRAM: begin
        if (timer_zero) begin
          next_state = ST_STANDBY;
        end
      end
      ST_ENTER: begin
        if (timer_zero) begin
          next_state = ST_DEEP;
        end
      end
      ST_DEEP: begin
        if (cs_rise && go_resume) begin
          next_state = ST_EXIT;
          next_timer = fsp_pkg::EXIT_CYC;
        end
      end
      ST_EXIT: begin
        // frames seen here are dropped; the host must hold off
        if (timer_zero) begin
          next_state = ST_STANDBY;
        end
      end
      default: begin
        next_state = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= ST_STANDBY;
      timer <= 16'h0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REWRITE_START <= 1'b0;
      REWRITE_BUF2 <= 1'b0;
      REWRITE_PAGE <= '0;
    end else begin
      REWRITE_START <= launch_rw;
      if (launch_rw) begin
        REWRITE_BUF2 <= rw_opc[0];
        REWRITE_PAGE <= rw_page;
      end
    end
  end

  assign REWRITE_COPY = state == ST_COPY;
  assign REWRITE_PROGRAM = state == ST_PROGRAM;
  assign DEEP_POWER = state == ST_DEEP;

  // ------------------------------------------------------------
  // status byte output
  // ------------------------------------------------------------
  logic stat_on;
  logic [2:0] out_idx;
  logic [7:0] snap;
  logic so_bit;
  logic so_oe_n;
  logic rdy;

  wire [7:0] status_now = {
    !busy,
    COMP_MISMATCH,
    fsp_pkg::DENSITY_CODE,
    PROTECT_ON,
    PAGE_512
  };
  // status is refused only around power-down, never for busy
  wire stat_allowed = state != ST_ENTER && state != ST_DEEP && state != ST_EXIT;
  wire stat_cmd = nbits == 6'h07 && {shift[6:0], si_q[1]} == fsp_pkg::OP_STATUS;

  always_ff @(posedge SYS_CLK) begin
    if (RST || !cs_low) begin
      stat_on <= 1'b0;
    end else if (sck_rise && stat_cmd && stat_allowed) begin
      stat_on <= 1'b1;
    end
  end

  // whole byte is snapped at its first bit so each byte is coherent
  always_ff @(posedge SYS_CLK) begin
    if (RST || !cs_low) begin
      out_idx <= 3'h7;
      snap <= 8'h00;
      so_bit <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (stat_on && sck_fall) begin
      so_oe_n <= 1'b0;
      out_idx <= out_idx - 3'h1;
      if (out_idx == 3'h7) begin
        snap <= status_now;
        so_bit <= status_now[7];
      end else begin
        so_bit <= snap[out_idx];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdy <= 1'b1;
    end else begin
      rdy <= !busy;
    end
  end

  assign LINK.so = so_bit;
  assign LINK.so_oe_n = so_oe_n;
  assign LINK.rdy = rdy;

endmodule // fsp_device
`default_nettype wire

//--- hw/fsp_host.sv
// controller end: AXI4-Lite registers driving the serial link
`default_nettype none
module fsp_host (
  input wire logic SYS_CLK,
  input wire logic RST,
  fsp_link_if.host LINK,
  input wire logic [fsp_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [fsp_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} fsp_host_state_type;

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  logic aw_full;
  logic w_full;
  logic [fsp_pkg::AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] cmd_reg;
  logic cfg_page512;
  logic [15:0] wear_cnt;
  logic wear_due;
  logic [7:0] rx;
  fsp_host_state_type hstate;

  wire eng_busy = hstate != H_IDLE;
  wire wr_cmd = awaddr_q == fsp_pkg::REG_CMD;
  wire wr_cfg = awaddr_q == fsp_pkg::REG_CFG;
  wire wr_wear = awaddr_q == fsp_pkg::REG_WEAR;
  wire wr_ok = (wr_cmd && !eng_busy) || wr_cfg || wr_wear || awaddr_q == fsp_pkg::REG_STAT;
  wire do_wr = aw_full && w_full && !S_AXI_BVALID;
  wire start = do_wr && wr_cmd && !eng_busy && wstrb_q == 4'hF;

  assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= fsp_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  wire [31:0] stat_word = {15'h0, wear_due, rx, 7'h00, eng_busy};
  wire ar_hit = S_AXI_ARADDR == fsp_pkg::REG_CMD || S_AXI_ARADDR == fsp_pkg::REG_STAT ||
    S_AXI_ARADDR == fsp_pkg::REG_CFG || S_AXI_ARADDR == fsp_pkg::REG_WEAR;
  wire [31:0] rd_mux =
    S_AXI_ARADDR == fsp_pkg::REG_CMD ? cmd_reg :
    S_AXI_ARADDR == fsp_pkg::REG_STAT ? stat_word :
    S_AXI_ARADDR == fsp_pkg::REG_CFG ? {31'h0, cfg_page512} :
    S_AXI_ARADDR == fsp_pkg::REG_WEAR ? {16'h0, wear_cnt} : 32'h0;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= fsp_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= ar_hit ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // command and wear registers
  // ------------------------------------------------------------
  wire [1:0] req_op = wdata_q[fsp_pkg::CMD_OP_LSB +: 2];
  wire [fsp_pkg::PAGE_W-1:0] req_page = wdata_q[fsp_pkg::CMD_PAGE_LSB +: fsp_pkg::PAGE_W];
  wire is_rw = req_op == fsp_pkg::HOP_REWRITE;
  wire wear_clr = do_wr && wr_wear;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cmd_reg <= 32'h0;
      cfg_page512 <= 1'b0;
      wear_cnt <= 16'h0000;
      wear_due <= 1'b0;
    end else begin
      if (start) begin
        cmd_reg <= wdata_q;
      end
      if (do_wr && wr_cfg && wstrb_q[0]) begin
        cfg_page512 <= wdata_q[0];
      end
      // a rewrite issued with the clear still counts: set wins
      if (start && is_rw) begin
        wear_cnt <= wear_clr ? 16'h0001 : wear_cnt + 16'h0001;
      end else if (wear_clr) begin
        wear_cnt <= 16'h0000;
      end
      if (start && is_rw && wear_cnt + 16'h0001 >= fsp_pkg::WEAR_LIMIT) begin
        wear_due <= 1'b1;
      end else if (wear_clr) begin
        wear_due <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // frame builder
  // ------------------------------------------------------------
  wire [23:0] rw_addr = cfg_page512 ? {3'h0, req_page, 9'h000} : {2'h0, req_page, 10'h000};
  wire [7:0] req_opc =
    req_op == fsp_pkg::HOP_STATUS ? fsp_pkg::OP_STATUS :
    req_op == fsp_pkg::HOP_POWERDOWN ? fsp_pkg::OP_POWERDOWN :
    req_op == fsp_pkg::HOP_RESUME ? fsp_pkg::OP_RESUME :
    wdata_q[fsp_pkg::CMD_BUF2_BIT] ? fsp_pkg::OP_REWRITE_BUF2 : fsp_pkg::OP_REWRITE_BUF1;
  wire [31:0] req_frame = {req_opc, is_rw ? rw_addr : 24'h000000};
  wire [5:0] req_len = is_rw ? fsp_pkg::REWRITE_BITS :
    req_op == fsp_pkg::HOP_STATUS ? fsp_pkg::STATUS_BITS : fsp_pkg::CMD_BITS;
  wire [15:0] req_gap = req_op == fsp_pkg::HOP_RESUME ? fsp_pkg::EXIT_WAIT_CYC :
    req_op == fsp_pkg::HOP_POWERDOWN ? fsp_pkg::ENTRY_WAIT_CYC : fsp_pkg::CS_HIGH_CYC;

  // ------------------------------------------------------------
  // serial engine
  // ------------------------------------------------------------
  logic [1:0] so_q;
  logic [31:0] frame;
  logic [5:0] len;
  logic [5:0] bitn;
  logic [4:0] ph;
  logic [15:0] gap;
  logic cs_n;
  logic sck;
  logic si;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      so_q <= 2'h3;
    end else begin
      so_q <= {so_q[0], LINK.so_line};
    end
  end

  wire bit_end = ph == fsp_pkg::SCK_LAST;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      hstate <= H_IDLE;
      frame <= 32'h0;
      len <= 6'h00;
      bitn <= 6'h00;
      ph <= 5'h00;
      gap <= 16'h0000;
      rx <= 8'h00;
      cs_n <= 1'b1;
      sck <= 1'b0;
      si <= 1'b0;
    end else begin
      case (hstate)
        H_IDLE: begin
          if (start) begin
            frame <= {req_frame[30:0], 1'b0};
            si <= req_frame[31];
            len <= req_len;
            gap <= req_gap;
            bitn <= 6'h00;
            ph <= 5'h00;
            cs_n <= 1'b0;
            hstate <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          ph <= bit_end ? 5'h00 : ph + 5'h01;
          if (ph == fsp_pkg::SCK_HALF - 5'h01) begin
            sck <= 1'b1;
          end
          if (bit_end) begin
            sck <= 1'b0;
            bitn <= bitn + 6'h01;
            frame <= {frame[30:0], 1'b0};
            si <= frame[31];
            // only status frames load the byte, so a rewrite cannot clobber it
            if (bitn >= fsp_pkg::CMD_BITS && len == fsp_pkg::STATUS_BITS) begin
              rx <= {rx[6:0], so_q[1]};
            end
            if (bitn == len - 6'h01) begin
              cs_n <= 1'b1;
              si <= 1'b0;
              hstate <= H_GAP;
            end
          end
        end
        H_GAP: begin
          // chip select stays high for the exit, entry or minimum deselect time
          if (gap == 16'h0000) begin
            hstate <= H_IDLE;
          end else begin
            gap <= gap - 16'h0001;
          end
        end
        default: begin
          hstate <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.cs_n = cs_n;
  assign LINK.sck = sck;
  assign LINK.si = si;

endmodule // fsp_host
`default_nettype wire

//--- sim/fsp_link_monitor.sv
// link checker: timing relations on the joined serial link
`default_nettype none
module fsp_link_monitor (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic rdy,
  input wire logic so_line
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // a stuck busy would hang every host poll, so bound it
  logic [10:0] low_cnt;
  always_ff @(posedge SYS_CLK) begin
    if (RST || rdy) begin
      low_cnt <= 11'h000;
    end else begin
      low_cnt <= low_cnt + 11'h001;
    end
  end
  sequence s_sck_high;
    sck [*8] ##1 !sck;
  endsequence
  sequence s_gap;
    cs_n [*5];
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_sck_shape: assert property ($rose(sck) |-> s_sck_high)
    else $error("sck high phase wrong");
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("sck moves outside frame");
  a_si_steady: assert property (sck && $past(sck) |-> $stable(si))
    else $error("si moved while sck high");
  a_frame_gap: assert property ($rose(cs_n) |-> s_gap)
    else $error("chip select gap too short");
  a_so_released: assert property (cs_n [*5] |-> so_oe_n)
    else $error("so driven after frame");
  a_drive_in_frame: assert property ($fell(so_oe_n) |-> !cs_n && !sck)
    else $error("so driven at wrong moment");
  a_so_steady: assert property (!so_oe_n && sck && $past(sck) |-> $stable(so))
    else $error("so moved while sck high");
  a_busy_after_cs: assert property ($fell(rdy) |-> cs_n)
    else $error("busy began inside frame");
  a_busy_bound: assert property (low_cnt <= 11'h6A4)
    else $error("busy too long");
  a_line_idle: assert property (so_oe_n |-> so_line)
    else $error("released so line not high");
endmodule // fsp_link_monitor
`default_nettype wire

//--- sim/flash_rewrite_status_powerdown_tb.sv
// bench: controller and flash end joined over the link
`default_nettype none
module flash_rewrite_status_powerdown_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ext_busy = 1'h0;
  logic comp = 1'h0;
  logic prot = 1'h0;
  logic p512 = 1'h0;
  logic rw_start, rw_buf2, rw_copy, rw_prog, deep;
  logic [11:0] rw_page;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [12:0] exp_q[$];
  logic [31:0] seed = 32'h5B;
  int errors = 0;
  int comparisons = 0;
  int rewrites = 0;
  always #12.5 clk = ~clk;
  fsp_link_if link ();
  fsp_device i_fsp_device (.SYS_CLK(clk), .RST(rst), .LINK(link.device), .EXT_BUSY(ext_busy),
    .COMP_MISMATCH(comp), .PROTECT_ON(prot), .PAGE_512(p512), .REWRITE_START(rw_start),
    .REWRITE_BUF2(rw_buf2), .REWRITE_PAGE(rw_page), .REWRITE_COPY(rw_copy),
    .REWRITE_PROGRAM(rw_prog), .DEEP_POWER(deep));
  fsp_host i_fsp_host (.SYS_CLK(clk), .RST(rst), .LINK(link.host), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  fsp_link_monitor i_fsp_link_monitor (.SYS_CLK(clk), .RST(rst), .cs_n(link.cs_n),
    .sck(link.sck), .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n), .rdy(link.rdy),
    .so_line(link.so_line));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] expb(input logic busy);
    return {~busy, comp, fsp_pkg::DENSITY_CODE, prot, p512};
  endfunction
  function automatic logic sig(input int k);
    case (k)
      0: return rw_start;
      1: return link.rdy;
      2: return deep;
      3: return rw_prog;
      4: return awready && wready;
      5: return bvalid;
      6: return arready;
      default: return rvalid;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic watch(input int k, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sig(k) !== v && n < lim);
  endtask
  task automatic need(input int k, input int lim);
    int n;
    watch(k, 1'h1, lim, n);
    if (sig(k) !== 1'h1) begin
      errors++;
      $display("[FAIL] wait %0d expected done seen timeout", k);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    need(4, 50);
    @(posedge clk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    bready <= 1'h1;
    need(5, 50);
    r = bresp;
    @(posedge clk);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    need(6, 50);
    @(posedge clk);
    arvalid <= 1'h0;
    rready <= 1'h1;
    need(7, 50);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
  endtask
  task automatic idle();
    logic [31:0] s;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(fsp_pkg::REG_STAT, s, r);
      n++;
    end while (s[fsp_pkg::STAT_BUSY_BIT] !== 1'h0 && n < 600);
    chk(n < 600, 1'h1, "host idle");
    if (n >= 600) begin
      wrap_up();
    end
  endtask
  task automatic sts(input logic [7:0] e);
    logic [31:0] s;
    logic [1:0] r;
    idle();
    wr(fsp_pkg::REG_CMD, {30'h0, fsp_pkg::HOP_STATUS}, r);
    idle();
    rd(fsp_pkg::REG_STAT, s, r);
    chk(s[15:8], e, "status byte");
  endtask
  task automatic rewrite(input logic b2, input logic [11:0] pg, input logic go);
    logic [1:0] r;
    int n;
    idle();
    exp_q.push_back({b2, pg});
    wr(fsp_pkg::REG_CMD, {4'h0, pg, 13'h0, b2, fsp_pkg::HOP_REWRITE}, r);
    rewrites++;
    chk(r, fsp_pkg::RESP_OKAY, "cmd resp");
    wr(fsp_pkg::REG_CMD, 32'h0, r);
    chk(r, fsp_pkg::RESP_SLVERR, "busy cmd resp");
    watch(0, 1'h1, 700, n);
    chk(n < 700, go, "launch");
    if (go && n >= 700) begin
      wrap_up();
    end
    if (go) begin
      @(negedge clk);
      chk({rw_buf2, rw_page, rw_copy}, {exp_q.pop_front(), 1'h1}, "args");
      sts(expb(1'h1));
      watch(3, 1'h1, 1200, n);
      chk(n < 1200, 1'h1, "program phase");
      if (n >= 1200) begin
        wrap_up();
      end
      need(1, 1700);
    end else begin
      exp_q.delete();
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({link.rdy, deep, link.cs_n}, 3'h5, "after reset");
    sts(expb(1'h0));
    for (int i = 0; i < 4; i++) begin
      s = rnd();
      comp <= s[0];
      prot <= s[1];
      p512 <= i[1];
      wr(fsp_pkg::REG_CFG, {31'h0, i[1]}, r);
      rewrite(i[0], s[15:4], 1'h1);
      sts(expb(1'h0));
      $display("rewrite test %0d done", i);
    end
    ext_busy <= 1'h1;
    sts(expb(1'h1));
    rewrite(1'h0, 12'(rnd()), 1'h0);
    ext_busy <= 1'h0;
    $display("busy test done");
    wr(fsp_pkg::REG_CMD, {30'h0, fsp_pkg::HOP_POWERDOWN}, r);
    need(2, 900);
    rewrite(1'h1, 12'h001, 1'h0);
    sts(8'hFF);
    wr(fsp_pkg::REG_CMD, {30'h0, fsp_pkg::HOP_RESUME}, r);
    watch(2, 1'h0, 1500, s);
    chk(deep, 1'h0, "resumed");
    if (deep !== 1'h0) begin
      wrap_up();
    end
    sts(expb(1'h0));
    $display("power-down test done");
    rd(8'h10, s, r);
    chk(r, fsp_pkg::RESP_SLVERR, "unmapped read resp");
    chk(s, 32'h0, "unmapped read data");
    wr(8'h10, 32'h1, r);
    chk(r, fsp_pkg::RESP_SLVERR, "unmapped write");
    rd(fsp_pkg::REG_WEAR, s, r);
    chk(s[15:0], 16'(rewrites), "wear count");
    wr(fsp_pkg::REG_WEAR, 32'h0, r);
    rd(fsp_pkg::REG_WEAR, s, r);
    chk(s, 32'h0, "wear cleared");
    $display("register test done");
    wrap_up();
  end
endmodule // flash_rewrite_status_powerdown_tb
`default_nettype wire
